/* can_mode_regs.svh */
// Register offsets, field positions, reset values and timing counts of the mode controller
`ifndef CAN_MODE_REGS_SVH
`define CAN_MODE_REGS_SVH

`define MCR_OFFSET        12'h000
`define MSR_OFFSET        12'h004
`define BTR_OFFSET        12'h01c
`define FMR_OFFSET        12'h200
`define FAR_OFFSET        12'h21c

`define MCR_INIT_BIT      0
`define MCR_SLEEP_BIT     1
`define MCR_OPT_LSB       2
`define MCR_OPT_MSB       7
`define MSR_INIT_ACK_BIT  0
`define MSR_SLEEP_ACK_BIT 1
`define MSR_RX_BIT        2
`define FMR_FILT_INIT_BIT 0

`define MCR_RESET         32'h0000_0002
`define BTR_RESET         32'h0123_0000
`define FMR_RESET         32'h0000_0001
`define FAR_RESET         32'h0000_0000

`define IDLE_BITS         11
`define BIT_PRESC_MSB     9
`define BIT_SEG_LSB       16
`define BIT_SEG_MSB       22

`endif

/* can_mode_pkg.sv */
// Types shared by the mode controller
package can_mode_pkg;
    typedef enum logic [1:0] {
        MODE_SLEEP = 2'b00,
        MODE_INIT  = 2'b01,
        MODE_SYNC  = 2'b10,
        MODE_NORM  = 2'b11
    } mode_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    typedef struct packed {
        logic tx_en;
        logic rx_en;
    } traffic_s;
endpackage : can_mode_pkg

/* can_mode_control.sv */
// Operating-mode controller: sleep, initialization and normal, with bus-idle synchronisation
// Overview of operation
// - After reset the controller sits in sleep mode with the transmit pull-up on.
// - Software asks for initialization or sleep through the two request bits of the control register.
// - On really entering a mode the controller sets its acknowledge flag and turns the pull-up off.
// - Normal mode holds exactly while both acknowledge flags are clear.
// - Normal mode is entered only after 11 consecutive recessive bits on the receive pin.
// - Software clears the init request to leave; the mode is left once hardware clears the acknowledge.
// - In initialization mode no traffic passes and the transmit pin is held recessive.
// - Entering initialization mode leaves all configuration registers untouched.
// - While the filter init bit is 1 no message is received.
//
// The APB interface to the registers and the address map were left to the implementer.
`include "can_mode_regs.svh"

module can_mode_control #(
    parameter int BANKS = 28
) (
    input  wire logic                    mclk,
    input  wire logic                    reset_n,
    input  wire can_mode_pkg::apb_req_s  apb_req,
    output can_mode_pkg::apb_rsp_s       apb_rsp,
    input  wire logic                    bus_rx_in,
    input  wire logic                    core_tx_bit,
    output logic                         bus_tx_out,
    output logic                         bus_tx_pullup,
    output can_mode_pkg::traffic_s       traffic,
    output logic [BANKS-1:0]             filter_active
);
    import can_mode_pkg::*;

    // ************************************************************
    // Register storage and APB decode
    // ************************************************************
    logic [31:0] mcr_r;
    logic [31:0] btr_r;
    logic [31:0] fmr_r;
    logic [31:0] far_r;
    logic [31:0] rdata_r;
    mode_e       mode_r;
    mode_e       mode_nxt;
    logic        pullup_r;

    wire logic wr_en   = apb_req.psel && apb_req.penable && apb_req.pwrite;
    wire logic rd_en   = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    wire logic hit_mcr = apb_req.paddr == `MCR_OFFSET;
    wire logic hit_msr = apb_req.paddr == `MSR_OFFSET;
    wire logic hit_btr = apb_req.paddr == `BTR_OFFSET;
    wire logic hit_fmr = apb_req.paddr == `FMR_OFFSET;
    wire logic hit_far = apb_req.paddr == `FAR_OFFSET;
    wire logic hit_any = hit_mcr | hit_msr | hit_btr | hit_fmr | hit_far;

    wire logic init_req  = mcr_r[`MCR_INIT_BIT];
    wire logic sleep_req = mcr_r[`MCR_SLEEP_BIT];
    wire logic filter_init_mode = fmr_r[`FMR_FILT_INIT_BIT];
    wire logic init_ack  = (mode_r == MODE_INIT) || (mode_r == MODE_SYNC);
    wire logic sleep_ack = mode_r == MODE_SLEEP;
    wire logic in_normal = !init_ack && !sleep_ack;

    // ************************************************************
    // Receive pin synchroniser
    // ************************************************************
    logic rx_meta_r;
    logic rx_sync_r;

    always_ff @(posedge mclk) begin
        rx_meta_r <= bus_rx_in;
        rx_sync_r <= rx_meta_r;
    end

    // ************************************************************
    // Bit-time divider and idle counter
    // ************************************************************
    // Bit time from the timing register: (prescaler+1) * (segments+1) clocks
    wire logic [9:0]  presc = btr_r[`BIT_PRESC_MSB:0];
    wire logic [6:0]  segs  = btr_r[`BIT_SEG_MSB:`BIT_SEG_LSB];
    // Widened before the product so the longest bit time cannot wrap
    wire logic [17:0] bit_len = (18'(presc) + 18'h1) * (18'(segs) + 18'h1);
    logic [17:0] bit_cnt_r;
    logic [3:0]  idle_cnt_r;
    wire logic   bit_tick = bit_cnt_r >= bit_len - 18'h1;
    wire logic   idle_done = idle_cnt_r == 4'(`IDLE_BITS);

    always_ff @(posedge mclk) begin
        if (!reset_n || mode_r != MODE_SYNC || bit_tick) begin
            bit_cnt_r <= 18'h0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 18'h1;
        end
    end

    // Any dominant sample restarts the count of recessive bits
    always_ff @(posedge mclk) begin
        if (!reset_n || mode_r != MODE_SYNC || !rx_sync_r) begin
            idle_cnt_r <= 4'h0;
        end else if (bit_tick && !idle_done) begin
            idle_cnt_r <= idle_cnt_r + 4'h1;
        end
    end

    // ************************************************************
    // Mode machine
    // ************************************************************
    // Init request takes priority over sleep when both are set
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            MODE_SLEEP: if (init_req) mode_nxt = MODE_INIT;
                        else if (!sleep_req) mode_nxt = MODE_SYNC;
            MODE_INIT:  if (!init_req) mode_nxt = sleep_req ? MODE_SLEEP : MODE_SYNC;
            MODE_SYNC:  if (init_req) mode_nxt = MODE_INIT;
                        else if (sleep_req) mode_nxt = MODE_SLEEP;
                        else if (idle_done) mode_nxt = MODE_NORM;
            MODE_NORM:  if (init_req) mode_nxt = MODE_INIT;
                        else if (sleep_req) mode_nxt = MODE_SLEEP;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mode_r <= MODE_SLEEP;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Pull-up stays only until the controller first leaves its reset sleep
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pullup_r <= 1'b1;
        end else if (mode_nxt != MODE_SLEEP) begin
            pullup_r <= 1'b0;
        end
    end

    // ************************************************************
    // Register writes and read data
    // ************************************************************
    // Mode changes touch no configuration register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mcr_r <= `MCR_RESET;
            btr_r <= `BTR_RESET;
            fmr_r <= `FMR_RESET;
            far_r <= `FAR_RESET;
        end else if (wr_en) begin
            if (hit_mcr) mcr_r <= {24'h0, apb_req.pwdata[`MCR_OPT_MSB:0]};
            if (hit_btr && init_ack) btr_r <= apb_req.pwdata;
            if (hit_fmr) fmr_r <= {31'h0, apb_req.pwdata[`FMR_FILT_INIT_BIT]};
            if (hit_far) far_r <= {{(32-BANKS){1'b0}}, apb_req.pwdata[BANKS-1:0]};
        end
    end

    wire logic [31:0] msr_val = {29'h0, rx_sync_r, sleep_ack, init_ack};
    wire logic [31:0] rd_mux  = hit_mcr ? mcr_r :
                                hit_msr ? msr_val :
                                hit_btr ? btr_r :
                                hit_fmr ? fmr_r :
                                hit_far ? far_r : 32'h0;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rdata_r <= 32'h0;
        end else if (rd_en) begin
            rdata_r <= rd_mux;
        end
    end

    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !hit_any;
    assign apb_rsp.prdata  = rdata_r;

    // ************************************************************
    // Pin and traffic control
    // ************************************************************
    // Top option bit lets software drop the pull-up while still asleep
    assign bus_tx_pullup   = pullup_r && !mcr_r[`MCR_OPT_MSB];
    assign bus_tx_out      = in_normal ? core_tx_bit : 1'b1;
    assign traffic.tx_en   = in_normal;
    assign traffic.rx_en   = in_normal && !filter_init_mode;
    assign filter_active   = far_r[BANKS-1:0];

    // ************************************************************
    // Checks
    // ************************************************************
    normal_exact_a: assert property (@(posedge mclk) disable iff (!reset_n)
        traffic.tx_en == (!msr_val[0] && !msr_val[1])) else $error("normal flag mismatch");
    init_recessive_a: assert property (@(posedge mclk) disable iff (!reset_n)
        init_ack |-> bus_tx_out && !traffic.tx_en) else $error("tx not recessive in init");
    filter_rx_a: assert property (@(posedge mclk) disable iff (!reset_n)
        filter_init_mode |-> !traffic.rx_en) else $error("rx during filter init");
    sync_needed_a: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(in_normal) |-> $past(idle_cnt_r) == 4'(`IDLE_BITS)) else $error("normal before idle");
    init_enter_a: assert property (@(posedge mclk) disable iff (!reset_n)
        init_req && !init_ack |=> init_ack) else $error("init not acknowledged");
    ack_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(init_req) && !sleep_req |=> init_ack) else $error("init ack dropped early");
    reset_sleep_a: assert property (@(posedge mclk)
        !reset_n |=> sleep_ack && bus_tx_pullup) else $error("not asleep after reset");
    btr_keep_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !init_ack |=> $stable(btr_r)) else $error("timing changed outside init");
    sleep_enter_a: assert property (@(posedge mclk) disable iff (!reset_n)
        sleep_req && !init_req && !sleep_ack |=> sleep_ack) else $error("sleep not acknowledged");
    pullup_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !sleep_ack |-> !bus_tx_pullup) else $error("pull-up on outside sleep");
    sleep_pullup_a: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(sleep_ack) |-> !bus_tx_pullup) else $error("pull-up on in requested sleep");
    idle_restart_a: assert property (@(posedge mclk) disable iff (!reset_n)
        mode_r == MODE_SYNC && !rx_sync_r |=> idle_cnt_r == 4'h0) else $error("idle count kept a dominant bit");
    rx_gate_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !in_normal |-> !traffic.rx_en) else $error("rx enabled outside normal");

    cov_normal_c: cover property (@(posedge mclk) $rose(in_normal));
    cov_abort_c: cover property (@(posedge mclk) mode_r == MODE_SYNC ##1 mode_r == MODE_SLEEP);
    cov_init_c: cover property (@(posedge mclk) $rose(init_ack) && !$past(sleep_ack));
    cov_sleep_c: cover property (@(posedge mclk) reset_n && $rose(sleep_ack));
endmodule : can_mode_control

/* can_bus_node.sv */
// Model of the other stations sharing the bus line
module can_bus_node (
    input  wire logic mclk,
    input  wire logic busy,
    input  wire logic tx_in,
    output logic      rx_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       node_bit;
    logic [2:0] run_r;

    initial node_bit = 1'b1;
    initial run_r = 3'h7;
    // Idle stations leave the line recessive; busy ones send random bits
    // Stuffing: a busy station never sends more than five recessive bits in a row
    always @(posedge mclk) begin
        run_r <= !node_bit ? 3'h0 : (run_r == 3'h7) ? run_r : run_r + 3'h1;
        if (!busy) begin
            node_bit <= 1'b1;
        end else if (node_bit && run_r >= 3'h4) begin
            node_bit <= 1'b0;
        end else begin
            node_bit <= 1'($urandom_range(0, 1));
        end
    end
    // Wired-AND line: any dominant bit wins
    assign rx_out = node_bit & tx_in;
endmodule : can_bus_node

/* can_mode_control_tb_top.sv */
// Self-checking bench for the operating-mode controller
`include "can_mode_regs.svh"

module can_mode_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import can_mode_pkg::*;
    logic        mclk, reset_n, bus_rx_in, core_tx_bit, bus_tx_out, bus_tx_pullup, busy, err;
    apb_req_s    req;
    apb_rsp_s    rsp;
    traffic_s    traffic;
    logic [27:0] filter_active;
    logic [31:0] rdat, far_val;
    int          n_errors, compares, n;

    can_mode_control i_can_mode_control (.mclk(mclk), .reset_n(reset_n), .apb_req(req), .apb_rsp(rsp),
        .bus_rx_in(bus_rx_in), .core_tx_bit(core_tx_bit), .bus_tx_out(bus_tx_out),
        .bus_tx_pullup(bus_tx_pullup), .traffic(traffic), .filter_active(filter_active));
    can_bus_node i_can_bus_node (.mclk(mclk), .busy(busy), .tx_in(bus_tx_out), .rx_out(bus_rx_in));

    // ****************
    // Tasks
    // ****************
    task automatic results();
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Callers wait for the falling edge first, so the rising edge's updates have landed
    task automatic pin(input string name, input logic exp, input logic got);
        chk(name, {31'h0, exp}, {31'h0, got});
    endtask : pin

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge mclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_errors++;
            results();
        end
        rdat = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : apb

    function automatic logic exp_tx(input logic normal, input logic bit_in);
        return normal ? bit_in : 1'b1;
    endfunction : exp_tx

    task automatic tx_loop(input logic normal);
        repeat (6) begin
            @(posedge mclk);
            core_tx_bit <= 1'($urandom_range(0, 1));
            @(negedge mclk);
            pin("tx_out", exp_tx(normal, core_tx_bit), bus_tx_out);
            pin("tx_en", normal, traffic.tx_en);
        end
    endtask : tx_loop

    // ****************
    // Sequence
    // ****************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        void'($urandom(8));
        {reset_n, core_tx_bit, busy, n_errors, compares} = '0;
        req = '0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        @(negedge mclk);
        pin("pullup", 1'b1, bus_tx_pullup);
        apb(1'b0, `MSR_OFFSET, 32'h0);
        chk("msr", 32'h2, rdat & 32'h3);
        // Bit timing is locked outside initialization
        apb(1'b1, `BTR_OFFSET, 32'h0);
        apb(1'b0, `BTR_OFFSET, 32'h0);
        chk("btr", `BTR_RESET, rdat);
        apb(1'b1, `MCR_OFFSET, 32'h1);
        apb(1'b0, `MSR_OFFSET, 32'h0);
        chk("msr", 32'h1, rdat & 32'h3);
        @(negedge mclk);
        pin("pullup", 1'b0, bus_tx_pullup);
        apb(1'b0, `BTR_OFFSET, 32'h0);
        chk("btr", `BTR_RESET, rdat);
        // One-clock bits keep the idle wait short
        apb(1'b1, `BTR_OFFSET, 32'h0);
        far_val = $urandom & 32'h0fff_ffff;
        apb(1'b1, `FAR_OFFSET, far_val);
        apb(1'b0, 12'h100, 32'h0);
        @(negedge mclk);
        pin("slverr", 1'b1, err);
        chk("banks", far_val, {4'h0, filter_active});
        tx_loop(1'b0);
        busy <= 1'b1;
        apb(1'b1, `MCR_OFFSET, 32'h0);
        repeat (30) @(posedge mclk);
        apb(1'b0, `MSR_OFFSET, 32'h0);
        chk("msr", 32'h1, rdat & 32'h3);
        busy <= 1'b0;
        n = 0;
        while (traffic.tx_en !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        chk("sync", 32'h1, 32'(n >= 11 && n <= 24));
        if (n >= 200) results();
        apb(1'b0, `MSR_OFFSET, 32'h0);
        chk("msr", 32'h0, rdat & 32'h3);
        tx_loop(1'b1);
        @(negedge mclk);
        pin("rx_en", 1'b0, traffic.rx_en);
        apb(1'b1, `FMR_OFFSET, 32'h0);
        @(negedge mclk);
        pin("rx_en", 1'b1, traffic.rx_en);
        apb(1'b1, `MCR_OFFSET, 32'h1);
        tx_loop(1'b0);
        @(negedge mclk);
        pin("rx_en", 1'b0, traffic.rx_en);
        apb(1'b0, `BTR_OFFSET, 32'h0);
        chk("btr", 32'h0, rdat);
        chk("banks", far_val, {4'h0, filter_active});
        apb(1'b1, `MCR_OFFSET, 32'h2);
        apb(1'b0, `MSR_OFFSET, 32'h0);
        chk("msr", 32'h2, rdat & 32'h3);
        @(negedge mclk);
        pin("pullup", 1'b0, bus_tx_pullup);
        // Wake with both requests clear, then fall back asleep before the bus is idle long enough
        apb(1'b1, `MCR_OFFSET, 32'h0);
        apb(1'b0, `MSR_OFFSET, 32'h0);
        chk("msr", 32'h1, rdat & 32'h3);
        apb(1'b1, `MCR_OFFSET, 32'h2);
        apb(1'b0, `MSR_OFFSET, 32'h0);
        chk("msr", 32'h2, rdat & 32'h3);
        results();
    end
endmodule : can_mode_control_tb_top
